// ==== hdl/pmu_clock_defines.svh ====
// register offsets, field positions, reset values and timing counts of the
// clock control unit; assumes a 32-bit byte-addressed classic Wishbone slave
//
// How it works
// R01 - only hard reset clears these registers
// R02 - output divider is field plus one, resets 1
// R03 - input divider is field plus one
// R04 - multiplier is field plus one, resets 13h
// R05 - bit 1 reads pll lock state
// R06 - bit 0 powers pll up, resets 0
// R07 - crystal stop bit, cleared by wake
// R08 - bit 30 picks crystal or pll source
// R09 - bit 24 halves usb clock from bus clock
// R10 - sdram clock runs only while bit 16 set
// R11 - bus clock is core over field plus one
// R12 - core clock is source over field plus one
// R13 - bit 31 gates core and cpu bus clock
// R14 - wake forces usb, memory, bridge, gpio gates on
// R15 - per peripheral gates, bits 25 and 20..0 untouched by wake
// R16 - block clocks 64k cycles after reset or restart
// R17 - gpio, rtc or usb activity wakes unit
// R18 - software picks pll only once locked
`ifndef PMU_CLOCK_DEFINES_SVH
`define PMU_CLOCK_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_PLL_CONFIGURATION 8'h00
`define OFF_CLOCK_SOURCE_AND_DIVIDERS 8'h04
`define OFF_PERIPHERAL_CLOCK_GATES 8'h08

// ----------------------------------------------------------------
// pll_configuration fields
// ----------------------------------------------------------------
`define POST_DIV_MSB 31
`define POST_DIV_LSB 28
`define PRE_DIV_MSB 27
`define PRE_DIV_LSB 24
`define MULT_MSB 23
`define MULT_LSB 16
`define LOCK_BIT 1
`define POWER_BIT 0
`define POST_DIV_RESET 4'h1
`define PRE_DIV_RESET 4'h0
`define MULT_RESET 8'h13

// ----------------------------------------------------------------
// clock_source_and_dividers fields
// ----------------------------------------------------------------
`define CRYSTAL_STOP_BIT 31
`define SOURCE_CHOICE_BIT 30
`define USB_HALF_BIT 24
`define SDRAM_ON_BIT 16
`define BUS_DIV_MSB 15
`define BUS_DIV_LSB 8
`define CORE_DIV_MSB 4
`define CORE_DIV_LSB 0

// ----------------------------------------------------------------
// peripheral_clock_gates fields
// ----------------------------------------------------------------
`define CPU_GATE_BIT 31
`define USB_GATE_BIT 30
`define GATES_RESET 32'hFEFFFFFF
`define GATES_WRITABLE 32'hFEFFFFFF
`define GATES_WAKE_FORCE 32'hFCE00000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SETTLE_COUNT 65536
`define SETTLE_BITS 16
`define WAKE_LINES 5

`endif

// ==== hdl/pmu_clock_pkg.sv ====
// types shared by the clock control unit and its settle counter
// assumes pmu_clock_defines.svh is on the include path
`include "pmu_clock_defines.svh"

package pmu_clock_pkg;

	// ----------------------------------------------------------------
	// settle counter state
	// ----------------------------------------------------------------
	typedef enum logic [0:0]
	{
		SETTLE_IDLE = 1'b0,
		SETTLE_RUN = 1'b1
	} settle_state_t;

	typedef struct packed
	{
		settle_state_t state;
		logic [`SETTLE_BITS-1:0] count;
	} settle_regs_t;

	// ----------------------------------------------------------------
	// main unit state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [3:0] post_multiply_divider;
		logic [3:0] pre_multiply_divider;
		logic [7:0] loop_multiplier;
		logic loop_power_on;
		logic crystal_stop;
		logic source_clock_choice;
		logic usb_half_rate;
		logic sdram_on;
		logic [7:0] bus_clock_divider;
		logic [4:0] core_clock_divider;
		logic [31:0] gates;
		logic ack;
		logic [31:0] rdata;
		logic lock_s1;
		logic lock_s2;
		logic [`WAKE_LINES-1:0] wake_s1;
		logic [`WAKE_LINES-1:0] wake_s2;
		logic [`WAKE_LINES-1:0] wake_d;
		logic [4:0] core_cnt;
		logic [7:0] bus_cnt;
		logic usb_phase;
		logic core_tick;
		logic [31:0] bus_ticks;
		logic usb_tick;
		logic sdram_tick;
		logic settle_start;
	} unit_regs_t;

endpackage

// ==== hdl/settle_if.sv ====
// link between the clock control unit and its crystal settle counter
// assumes both ends run on the same ref_clk
`timescale 1ns/1ns
`default_nettype none

interface settle_if;
	logic start;
	logic blocked;

	modport ctrl
	(
		output start,
		input blocked
	);

	modport timer
	(
		input start,
		output blocked
	);
endinterface

`default_nettype wire

// ==== hdl/crystal_settle_counter.sv ====
// counter that blocks clocks while the crystal settles
// assumes a one-cycle start pulse from the control unit on ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "pmu_clock_defines.svh"

module crystal_settle_counter
#(
	parameter int SETTLE_COUNT = `SETTLE_COUNT
)
(
	// clock and hard reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// control link
	settle_if.timer link
);

	localparam logic [`SETTLE_BITS-1:0] LAST = `SETTLE_BITS'(SETTLE_COUNT - 1);

	pmu_clock_pkg::settle_regs_t s_reg;
	pmu_clock_pkg::settle_regs_t s_next;

	// ----------------------------------------------------------------
	// next state: count from start to last, then release
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		unique case (s_reg.state)
			pmu_clock_pkg::SETTLE_IDLE:
			begin
				s_next.count = '0;
			end
			pmu_clock_pkg::SETTLE_RUN:
			begin
				s_next.count = s_reg.count + 1'b1;
				if (s_reg.count == LAST)
				begin
					s_next.state = pmu_clock_pkg::SETTLE_IDLE; // R16
					s_next.count = '0;
				end
			end
		endcase
		// restart from zero when the crystal comes back
		if (link.start)
		begin
			s_next.state = pmu_clock_pkg::SETTLE_RUN; // R16
			s_next.count = '0;
		end
	end

	// registers; hard reset starts a full settle period
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			s_reg.state <= pmu_clock_pkg::SETTLE_RUN; // R16
			s_reg.count <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign link.blocked = (s_reg.state == pmu_clock_pkg::SETTLE_RUN);

endmodule

`default_nettype wire

// ==== hdl/pmu_clock_control.sv ====
// clock control unit: pll setup, source choice, core and bus dividers,
// per peripheral bus clock gates and wake handling
// assumes ref_clk is the source clock timebase, rst_b is the hard reset,
// and pll lock and wake lines arrive asynchronously from pins
`timescale 1ns/1ns
`default_nettype none
`include "pmu_clock_defines.svh"

module pmu_clock_control
#(
	parameter int ADR_W = 8,
	parameter int SETTLE_COUNT = `SETTLE_COUNT
)
(
	// clock and hard reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// pll analog macro
	input wire logic pll_lock,
	output logic loop_power_on,
	output logic [3:0] pre_multiply_divider,
	output logic [7:0] loop_multiplier,
	output logic [3:0] post_multiply_divider,
	// crystal and source
	output logic crystal_enable,
	output logic source_is_pll,
	output logic clocks_blocked,
	// wake lines: gpio ports 2..0, rtc alarm, usb activity
	input wire logic [2:0] gpio_wake,
	input wire logic rtc_wake,
	input wire logic usb_wake,
	// derived clock enables
	output logic core_clk_en,
	output logic [31:0] bus_clk_en,
	output logic usb_clk_en,
	output logic sdram_clk_en
);

	pmu_clock_pkg::unit_regs_t s_reg;
	pmu_clock_pkg::unit_regs_t s_next;

	settle_if settle ();

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// merge write data into a word under the byte lane selects
	function automatic logic [31:0] merge_lanes(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// exact byte address match against a register offset
	function automatic logic hits(input logic [ADR_W-1:0] adr, input logic [7:0] off);
		return adr == ADR_W'(off);
	endfunction

	// ----------------------------------------------------------------
	// register images
	// ----------------------------------------------------------------
	logic [31:0] pll_word;
	logic [31:0] clk_word;

	// readback of pll_configuration and clock_source_and_dividers
	always_comb
	begin
		pll_word = '0;
		pll_word[`POST_DIV_MSB:`POST_DIV_LSB] = s_reg.post_multiply_divider;
		pll_word[`PRE_DIV_MSB:`PRE_DIV_LSB] = s_reg.pre_multiply_divider;
		pll_word[`MULT_MSB:`MULT_LSB] = s_reg.loop_multiplier;
		pll_word[`LOCK_BIT] = s_reg.lock_s2; // R05
		pll_word[`POWER_BIT] = s_reg.loop_power_on;
		clk_word = '0;
		clk_word[`CRYSTAL_STOP_BIT] = s_reg.crystal_stop;
		clk_word[`SOURCE_CHOICE_BIT] = s_reg.source_clock_choice;
		clk_word[`USB_HALF_BIT] = s_reg.usb_half_rate;
		clk_word[`SDRAM_ON_BIT] = s_reg.sdram_on;
		clk_word[`BUS_DIV_MSB:`BUS_DIV_LSB] = s_reg.bus_clock_divider;
		clk_word[`CORE_DIV_MSB:`CORE_DIV_LSB] = s_reg.core_clock_divider;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic req;
	logic wr;
	logic wake_event;
	logic running;
	logic core_raw;
	logic bus_raw;
	logic [31:0] pll_new;
	logic [31:0] clk_new;
	logic [31:0] gates_new;

	assign req = cyc_i && stb_i;
	// writes land on the edge where the master sees ack
	assign wr = req && we_i && s_reg.ack;
	// any fresh rising edge on a wake line
	assign wake_event = |(s_reg.wake_s2 & ~s_reg.wake_d); // R17
	// clocks run only with crystal on and settling done
	assign running = !s_reg.crystal_stop && !settle.blocked; // R16
	assign pll_new = merge_lanes(pll_word, dat_i, sel_i);
	assign clk_new = merge_lanes(clk_word, dat_i, sel_i);
	assign gates_new = merge_lanes(s_reg.gates, dat_i, sel_i);

	always_comb
	begin
		s_next = s_reg;

		// bus handshake: one wait state, ack for one cycle
		s_next.ack = req && !s_reg.ack;
		s_next.rdata = '0;
		if (req && !s_reg.ack && !we_i)
		begin
			if (hits(adr_i, `OFF_PLL_CONFIGURATION))
			begin
				s_next.rdata = pll_word;
			end
			else if (hits(adr_i, `OFF_CLOCK_SOURCE_AND_DIVIDERS))
			begin
				s_next.rdata = clk_word;
			end
			else if (hits(adr_i, `OFF_PERIPHERAL_CLOCK_GATES))
			begin
				s_next.rdata = s_reg.gates;
			end
		end

		// pin synchronisers and wake edge history
		s_next.lock_s1 = pll_lock;
		s_next.lock_s2 = s_reg.lock_s1;
		s_next.wake_s1 = {usb_wake, rtc_wake, gpio_wake};
		s_next.wake_s2 = s_reg.wake_s1;
		s_next.wake_d = s_reg.wake_s2;

		// register writes; unmapped offsets are acked and dropped
		if (wr && hits(adr_i, `OFF_PLL_CONFIGURATION))
		begin
			s_next.post_multiply_divider = pll_new[`POST_DIV_MSB:`POST_DIV_LSB]; // R02
			s_next.pre_multiply_divider = pll_new[`PRE_DIV_MSB:`PRE_DIV_LSB]; // R03
			s_next.loop_multiplier = pll_new[`MULT_MSB:`MULT_LSB]; // R04
			s_next.loop_power_on = pll_new[`POWER_BIT]; // R06
		end
		if (wr && hits(adr_i, `OFF_CLOCK_SOURCE_AND_DIVIDERS))
		begin
			s_next.crystal_stop = clk_new[`CRYSTAL_STOP_BIT]; // R07
			s_next.source_clock_choice = clk_new[`SOURCE_CHOICE_BIT]; // R08
			s_next.usb_half_rate = clk_new[`USB_HALF_BIT]; // R09
			s_next.sdram_on = clk_new[`SDRAM_ON_BIT]; // R10
			s_next.bus_clock_divider = clk_new[`BUS_DIV_MSB:`BUS_DIV_LSB]; // R11
			s_next.core_clock_divider = clk_new[`CORE_DIV_MSB:`CORE_DIV_LSB]; // R12
		end
		if (wr && hits(adr_i, `OFF_PERIPHERAL_CLOCK_GATES))
		begin
			// reserved bit 24 stays zero
			s_next.gates = gates_new & `GATES_WRITABLE; // R15
		end

		// wake wins over a write in the same cycle
		s_next.settle_start = 1'b0;
		if (wake_event)
		begin
			s_next.crystal_stop = 1'b0; // R07
			s_next.settle_start = s_reg.crystal_stop; // R16
			s_next.gates = s_next.gates | `GATES_WAKE_FORCE; // R13 R14
		end

		// core divider counts source cycles
		core_raw = 1'b0;
		bus_raw = 1'b0;
		if (running)
		begin
			if (s_reg.core_cnt >= s_reg.core_clock_divider)
			begin
				s_next.core_cnt = '0;
				core_raw = 1'b1; // R12
			end
			else
			begin
				s_next.core_cnt = s_reg.core_cnt + 1'b1;
			end
		end
		else
		begin
			s_next.core_cnt = '0;
		end

		// bus divider counts core cycles
		if (!running)
		begin
			s_next.bus_cnt = '0;
		end
		else if (core_raw)
		begin
			if (s_reg.bus_cnt >= s_reg.bus_clock_divider)
			begin
				s_next.bus_cnt = '0;
				bus_raw = 1'b1; // R11
			end
			else
			begin
				s_next.bus_cnt = s_reg.bus_cnt + 1'b1;
			end
		end

		// usb takes every bus tick or every other one
		if (!running)
		begin
			s_next.usb_phase = 1'b0;
		end
		else if (bus_raw)
		begin
			s_next.usb_phase = !s_reg.usb_phase;
		end

		// gated enables, registered toward the clock tree
		s_next.core_tick = core_raw && s_reg.gates[`CPU_GATE_BIT]; // R13
		s_next.bus_ticks = {32{bus_raw}} & s_reg.gates; // R15
		s_next.usb_tick = bus_raw && s_reg.gates[`USB_GATE_BIT]
			&& (!s_reg.usb_half_rate || s_reg.usb_phase); // R09
		s_next.sdram_tick = bus_raw && s_reg.sdram_on; // R10
	end

	// ----------------------------------------------------------------
	// state register; only the hard reset clears it
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			s_reg <= '0; // R01
			s_reg.post_multiply_divider <= `POST_DIV_RESET; // R02
			s_reg.pre_multiply_divider <= `PRE_DIV_RESET;
			s_reg.loop_multiplier <= `MULT_RESET; // R04
			s_reg.gates <= `GATES_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// settle counter
	// ----------------------------------------------------------------
	assign settle.start = s_reg.settle_start;

	crystal_settle_counter
	#(
		.SETTLE_COUNT(SETTLE_COUNT)
	)
	u_settle
	(
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.link(settle.timer)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dat_o = s_reg.rdata;
	assign ack_o = s_reg.ack;
	assign loop_power_on = s_reg.loop_power_on; // R06
	assign pre_multiply_divider = s_reg.pre_multiply_divider; // R03
	assign loop_multiplier = s_reg.loop_multiplier; // R04
	assign post_multiply_divider = s_reg.post_multiply_divider; // R02
	assign crystal_enable = !s_reg.crystal_stop; // R07
	assign source_is_pll = s_reg.source_clock_choice; // R08
	assign clocks_blocked = settle.blocked;
	assign core_clk_en = s_reg.core_tick;
	assign bus_clk_en = s_reg.bus_ticks;
	assign usb_clk_en = s_reg.usb_tick;
	assign sdram_clk_en = s_reg.sdram_tick;

endmodule

`default_nettype wire

// ==== verif/pmu_clock_control_asserts.sv ====
// checker for the clock control unit, bound to its top module
// assumes the one-wait-state wishbone answer and a short settle count
`timescale 1ns/1ns
`default_nettype none
`include "pmu_clock_defines.svh"

module pmu_clock_control_asserts
#(
	parameter int ADR_W = 8,
	parameter int SETTLE_COUNT = 8
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// controls
	input wire logic loop_power_on,
	input wire logic [3:0] post_multiply_divider,
	input wire logic source_is_pll,
	input wire logic crystal_enable,
	input wire logic clocks_blocked,
	input wire logic core_clk_en,
	input wire logic sdram_clk_en,
	// wake lines
	input wire logic [2:0] gpio_wake,
	input wire logic rtc_wake,
	input wire logic usb_wake
);
	logic wr0;
	logic wr4;
	logic sd_bit_reg;
	logic [19:0] blk_cnt_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// accepted writes to the pll and clock registers
	assign wr0 = ack_o && cyc_i && stb_i && we_i && adr_i == ADR_W'(`OFF_PLL_CONFIGURATION);
	assign wr4 = ack_o && cyc_i && stb_i && we_i && adr_i == ADR_W'(`OFF_CLOCK_SOURCE_AND_DIVIDERS);

	// shadow of the sdram enable and length of the blocked stretch
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			sd_bit_reg <= 1'b0;
		else if (wr4 && sel_i[2])
			sd_bit_reg <= dat_i[`SDRAM_ON_BIT];
		if (!rst_b || !clocks_blocked)
			blk_cnt_reg <= 20'h00000;
		else
			blk_cnt_reg <= blk_cnt_reg + 20'h00001;
	end

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_ack_answer;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

	property p_rdata_idle;
		!ack_o |-> dat_o == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");

	property p_power_write;
		wr0 && sel_i[0] |=> loop_power_on == $past(dat_i[`POWER_BIT]);
	endproperty
	a_power_write: assert property (p_power_write) else $error("power bit not written");

	property p_post_div_write;
		wr0 && sel_i[3] |=> post_multiply_divider == $past(dat_i[31:28]);
	endproperty
	a_post_div_write: assert property (p_post_div_write) else $error("post divider wrong");

	property p_source_write;
		wr4 && sel_i[3] |=> source_is_pll == $past(dat_i[`SOURCE_CHOICE_BIT]);
	endproperty
	a_source_write: assert property (p_source_write) else $error("source choice wrong");

	property p_wake_restart;
		$rose({gpio_wake, rtc_wake, usb_wake} != 5'h00) |-> ##[1:4] crystal_enable;
	endproperty
	a_wake_restart: assert property (p_wake_restart) else $error("wake kept crystal off");

	property p_blocked_quiet;
		clocks_blocked [*3] |-> !core_clk_en;
	endproperty
	a_blocked_quiet: assert property (p_blocked_quiet) else $error("core pulse while blocked");

	property p_settle_length;
		$fell(clocks_blocked) |-> blk_cnt_reg >= SETTLE_COUNT - 1 && blk_cnt_reg <= SETTLE_COUNT + 2;
	endproperty
	a_settle_length: assert property (p_settle_length) else $error("settle length wrong");

	property p_sdram_off;
		sdram_clk_en |-> sd_bit_reg || $past(sd_bit_reg) || $past(sd_bit_reg, 2);
	endproperty
	a_sdram_off: assert property (p_sdram_off) else $error("sdram clock while off");

	// main scenarios
	c_write: cover property (wr4);
	c_wake: cover property ($rose(rtc_wake));
	c_settled: cover property ($fell(clocks_blocked));
endmodule

bind pmu_clock_control pmu_clock_control_asserts #(.ADR_W(ADR_W), .SETTLE_COUNT(SETTLE_COUNT)) chk_u
(
	.ref_clk(ref_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.loop_power_on(loop_power_on), .post_multiply_divider(post_multiply_divider),
	.source_is_pll(source_is_pll), .crystal_enable(crystal_enable),
	.clocks_blocked(clocks_blocked), .core_clk_en(core_clk_en), .sdram_clk_en(sdram_clk_en),
	.gpio_wake(gpio_wake), .rtc_wake(rtc_wake), .usb_wake(usb_wake)
);

`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the clock control unit
// assumes the design and checker files are compiled before it
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic pll_lock = 1'b0;
	logic [2:0] gpio_wake = 3'h0;
	logic rtc_wake = 1'b0;
	logic usb_wake = 1'b0;
	logic [31:0] dat_o, bus_clk_en, r;
	logic ack_o, loop_power_on, crystal_enable, source_is_pll, clocks_blocked;
	logic core_clk_en, usb_clk_en, sdram_clk_en;
	logic [3:0] pre_multiply_divider, post_multiply_divider;
	logic [7:0] loop_multiplier;
	int miscompares = 0;
	int n_compared = 0;

	pmu_clock_control #(.ADR_W(8), .SETTLE_COUNT(8)) dut_u
	(
		.ref_clk(ref_clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .pll_lock(pll_lock),
		.loop_power_on(loop_power_on), .pre_multiply_divider(pre_multiply_divider),
		.loop_multiplier(loop_multiplier), .post_multiply_divider(post_multiply_divider),
		.crystal_enable(crystal_enable), .source_is_pll(source_is_pll),
		.clocks_blocked(clocks_blocked), .gpio_wake(gpio_wake), .rtc_wake(rtc_wake),
		.usb_wake(usb_wake), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
		.usb_clk_en(usb_clk_en), .sdram_clk_en(sdram_clk_en)
	);

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// read and compare
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000, 4'hF);
		chk(r, exp);
	endtask

	// hard reset for five cycles, then wait for the settle to end
	task rst();
		rst_b <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		settle();
	endtask

	task settle();
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (clocks_blocked !== 1'b0 && n < 100);
		if (n >= 100)
			miscompares++;
	endtask

	function logic pick(int k);
		case (k)
			0: return core_clk_en;
			1: return bus_clk_en[0];
			2: return usb_clk_en;
			default: return sdram_clk_en;
		endcase
	endfunction

	// cycles between two pulses of one enable; 300 means none seen
	task gap(input int k, input logic [31:0] exp);
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pick(k) !== 1'b1 && n < 300);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pick(k) !== 1'b1 && n < 300);
		chk(n, exp);
	endtask

	// verdict and end of run
	task conclude();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end

	// main sequence
	initial
	begin
		rst();
		rd(8'h00, 32'h10130000);
		rd(8'h04, 32'h00000000);
		rd(8'h08, 32'hFEFFFFFF);
		rd(8'h0C, 32'h00000000);
		pll_lock <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wb(1'b1, 8'h00, 32'hFFFFFFFF, 4'hF);
		rd(8'h00, 32'hFFFF0003);
		chk(pre_multiply_divider, 4'hF);
		chk(loop_multiplier, 8'hFF);
		chk(post_multiply_divider, 4'hF);
		wb(1'b1, 8'h00, 32'h00000000, 4'h1);
		rd(8'h00, 32'hFFFF0002);
		chk(loop_power_on, 1'b0);
		wb(1'b1, 8'h00, 32'h00000001, 4'h1);
		wb(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
		rd(8'h04, 32'hC101FF1F);
		chk({crystal_enable, source_is_pll}, 2'b01);
		// every wake line restarts the crystal and forces the gates
		for (int i = 0; i < 5; i++)
		begin
			wb(1'b1, 8'h08, 32'h00000000, 4'hF);
			wb(1'b1, 8'h04, 32'hC101FF1F, 4'hF);
			{usb_wake, rtc_wake, gpio_wake} <= 5'h01 << i;
			repeat (6) @(posedge ref_clk);
			rd(8'h08, 32'hFCE00000);
			rd(8'h04, 32'h4101FF1F);
			{usb_wake, rtc_wake, gpio_wake} <= 5'h00;
			repeat (3) @(posedge ref_clk);
		end
		wb(1'b1, 8'h08, 32'hFFFFFFFF, 4'hF);
		rd(8'h08, 32'hFEFFFFFF);
		wb(1'b1, 8'h04, 32'h40000203, 4'hF);
		settle();
		gap(0, 4);
		gap(1, 12);
		gap(2, 12);
		gap(3, 300);
		wb(1'b1, 8'h04, 32'h41010203, 4'hF);
		gap(2, 24);
		gap(3, 12);
		wb(1'b1, 8'h08, 32'h7FFFFFFF, 4'hF);
		gap(0, 300);
		rst();
		rd(8'h08, 32'hFEFFFFFF);
		rd(8'h04, 32'h00000000);
		conclude();
	end
endmodule

`default_nettype wire
